// ### inc/fpk_params.svh
// Offsets, field positions, reset values and timing counts of the front panel block
`ifndef FPK_PARAMS_SVH
`define FPK_PARAMS_SVH
`define FPK_CLK_NS 100
`define FPK_TICK_NS 1000000
`define FPK_TICK_CYC ((`FPK_TICK_NS + `FPK_CLK_NS - 1) / `FPK_CLK_NS)
`define FPK_HOLD_S 3
`define FPK_HOLD_TICKS (`FPK_HOLD_S * 1000)
`define FPK_BL_MIN 60
`define FPK_BL_TICKS (`FPK_BL_MIN * 60 * 1000)
`define FPK_DEB_MS 20
`define FPK_LCD_W 128
`define FPK_LCD_H 64
`define FPK_LCD_COLS 21
`define FPK_LCD_ROWS 8
`define FPK_MAX_CTRL_OBJ 6
`define FPK_MAX_STAT_OBJ 8
`define FPK_MAX_MEAS 6
`define FPK_OFF_CTRL 8'h00
`define FPK_OFF_LATCH 8'h04
`define FPK_OFF_STATUS 8'h08
`define FPK_OFF_KEYEVT 8'h0C
`define FPK_OFF_CONTRAST 8'h10
`define FPK_OFF_PASSWORD 8'h14
`define FPK_OFF_ALARMS 8'h18
`define FPK_OFF_DIAG 8'h1C
`define FPK_CTRL_CLR_BIT 0
`define FPK_CTRL_BLSRC_LSB 1
`define FPK_RST_CONTRAST 6'h20
`define FPK_RST_PASSWORD 16'h0000
`define FPK_RST_BLSRC 2'h0
`define FPK_K_CANCEL 0
`define FPK_K_UP 1
`define FPK_K_DOWN 2
`define FPK_K_LEFT 3
`define FPK_K_RIGHT 4
`define FPK_K_INFO 5
`define FPK_K_ENTER 6
`define FPK_K_PWR 7
`define FPK_K_CLRDI 8
`define FPK_K_BLDI 9
`define FPK_NPIN 10
`endif

// ### inc/fpk_pkg.sv
// Types shared by the front panel block
package fpk_pkg;
	typedef enum logic [2:0] {
		FPK_MENU = 3'b001,
		FPK_PWD = 3'b010,
		FPK_ADJ = 3'b100
	} fpk_mode_e;
	typedef enum logic [1:0] {
		FPK_BL_DI = 2'h0,
		FPK_BL_VIN = 2'h1,
		FPK_BL_VOUT = 2'h2,
		FPK_BL_OFF = 2'h3
	} fpk_blsrc_e;
endpackage : fpk_pkg

// ### hdl/fpk_debounce.sv
// Pin synchroniser and tick-based debouncer with edge pulses
`timescale 1ns/1ps
module fpk_debounce #(
	parameter int WIDTH = 10,
	parameter int DEB_TICKS = 20
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic tick,
	// Raw pins and cleaned results
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] clean,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	localparam int CW = $clog2(DEB_TICKS + 1);
	if (DEB_TICKS < 1 || WIDTH < 1) begin : g_chk
		$error("fpk_debounce: DEB_TICKS and WIDTH must be at least 1");
	end
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic s1_r, s2_r, s3_r;
		logic [CW-1:0] cnt_r;
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				s1_r <= 1'b0;
				s2_r <= 1'b0;
				s3_r <= 1'b0;
			end else begin
				s1_r <= raw[i];
				s2_r <= s1_r;
				s3_r <= s2_r;
			end
		end
		// A level only counts while the last two stages agree
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				cnt_r <= '0;
				clean[i] <= 1'b0;
				rise[i] <= 1'b0;
				fall[i] <= 1'b0;
			end else begin
				rise[i] <= 1'b0;
				fall[i] <= 1'b0;
				if (s2_r != s3_r || s3_r == clean[i]) begin
					cnt_r <= '0;
				end else if (cnt_r == CW'(DEB_TICKS)) begin
					cnt_r <= '0;
					clean[i] <= s3_r;
					rise[i] <= s3_r;
					fall[i] <= ~s3_r;
				end else if (tick) begin
					cnt_r <= cnt_r + CW'(1);
				end
			end
		end
	end
endmodule : fpk_debounce

// ### hdl/fpk_front_panel.sv
// Front panel keypad, indicator, latch, contrast and backlight logic behind an APB slave
//
// Function
// RULE_01 - Short cancel steps back; three second hold jumps to main menu start.
// RULE_02 - Up moves up or increments value; down moves down or decrements.
// RULE_03 - Left/right step parallel menus or pick the edited digit.
// RULE_04 - Info key shows details, opens password entry and contrast access.
// RULE_05 - Enter activates or confirms the selected function.
// RULE_06 - Power LED lit while auxiliary supply is present.
// RULE_07 - Error LED follows self-supervision relay exactly on internal fault.
// RULE_08 - Com LED lit or flashing while serial bus carries traffic.
// RULE_09 - Alarm LED lights when warning output group is activated.
// RULE_10 - Trip LED lights when opening command output is activated.
// RULE_11 - Non-latched alarm/trip LEDs go dark when their cause resets.
// RULE_12 - Each indicator and relay individually configurable as latching; power, error and com LEDs and self_sup_relay have no latch setting here.
// RULE_13 - Long cancel to initial display, then reset key clears all latches.
// RULE_14 - Acknowledging each alarm entry also reaches initial display for reset.
// RULE_15 - Latches also cleared by remote bus command or digital input.
// RULE_16 - Info+enter, four-digit password, confirm; then up/down adjust contrast.
// RULE_17 - Display is 128x64 pixels, 21 characters by eight rows.
// RULE_18 - Diagram holds at most six controllable and eight status objects.
// RULE_19 - Diagram shows at most six selected measurement values.
// RULE_20 - Setting picks backlight trigger: digital input, virtual input or output.
// RULE_21 - Rising trigger edge turns backlight on for 60 minutes.
// RULE_22 - New edge while lit restarts the full 60 minute period.
// RULE_23 - Keys debounced; cancel hold timed by a periodic time-base tick.
`timescale 1ns/1ps
`include "fpk_params.svh"
module fpk_front_panel #(
	parameter int TICK_CYC = `FPK_TICK_CYC,
	parameter int HOLD_TICKS = `FPK_HOLD_TICKS,
	parameter int BL_TICKS = `FPK_BL_TICKS,
	parameter int DEB_TICKS = `FPK_DEB_MS,
	parameter int RELAY_N = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Push-buttons and pins
	input wire logic [6:0] key_raw,
	input wire logic aux_supply_pin,
	input wire logic latch_clr_pin,
	input wire logic backlight_di_pin,
	// Relay internals
	input wire logic int_fault,
	input wire logic com_active,
	input wire logic com_traffic,
	input wire logic warning_output_group,
	input wire logic opening_command_output,
	input wire logic [2:0] app_src,
	input wire logic [RELAY_N-1:0] relay_src,
	input wire logic backlight_vin,
	input wire logic backlight_vout,
	input wire logic alarm_new,
	// Indicators and outputs
	output logic led_power,
	output logic led_error,
	output logic led_com,
	output logic led_alarm,
	output logic led_trip,
	output logic [2:0] led_app,
	output logic [RELAY_N-1:0] relay_out,
	output logic self_sup_relay,
	output logic restart_req,
	output logic backlight_on,
	output logic [5:0] contrast,
	output logic [8:0] nav_evt
);
	localparam int TW = $clog2(TICK_CYC + 1);
	localparam int HW = $clog2(HOLD_TICKS + 1);
	localparam int BW = $clog2(BL_TICKS + 1);
	localparam int CH = 5 + RELAY_N;
	if (RELAY_N < 1 || RELAY_N > 8 || TICK_CYC < 2 || HOLD_TICKS < 2 || BL_TICKS < 2) begin : g_chk
		$error("fpk_front_panel: parameter out of range");
	end

	// Time base
	logic [TW-1:0] tick_cnt_r;
	logic tick_r;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (tick_cnt_r == TW'(TICK_CYC - 1)); // RULE_23
			tick_cnt_r <= (tick_cnt_r == TW'(TICK_CYC - 1)) ? '0 : tick_cnt_r + TW'(1);
		end
	end

	logic [`FPK_NPIN-1:0] pin_clean, pin_rise, pin_fall;
	fpk_debounce #(.WIDTH(`FPK_NPIN), .DEB_TICKS(DEB_TICKS)) u_deb ( // RULE_23
		.clk_sys(clk_sys),
		.rst(rst),
		.tick(tick_r),
		.raw({backlight_di_pin, latch_clr_pin, aux_supply_pin, key_raw}),
		.clean(pin_clean),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// APB decode; zero wait states, read data captured in the setup cycle
	logic wr_en;
	logic sel_ok;
	assign wr_en = psel & penable & pwrite;
	assign pready = 1'b1;
	always_comb begin
		case (paddr)
			`FPK_OFF_CTRL, `FPK_OFF_LATCH, `FPK_OFF_STATUS, `FPK_OFF_KEYEVT,
			`FPK_OFF_CONTRAST, `FPK_OFF_PASSWORD, `FPK_OFF_ALARMS, `FPK_OFF_DIAG: sel_ok = 1'b1;
			default: sel_ok = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~sel_ok;

	logic [1:0] blsrc_r;
	logic [15:0] latch_cfg_r;
	logic [15:0] password_r;
	logic [19:0] diag_r;
	logic [8:0] evt_sticky_r;
	logic bus_clr_r;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			blsrc_r <= `FPK_RST_BLSRC;
			latch_cfg_r <= 16'h0000;
			password_r <= `FPK_RST_PASSWORD;
			diag_r <= 20'h00000;
			bus_clr_r <= 1'b0;
		end else begin
			bus_clr_r <= wr_en && paddr == `FPK_OFF_CTRL && pwdata[`FPK_CTRL_CLR_BIT]; // RULE_15
			if (wr_en && paddr == `FPK_OFF_CTRL)
				blsrc_r <= pwdata[`FPK_CTRL_BLSRC_LSB +: 2]; // RULE_20
			if (wr_en && paddr == `FPK_OFF_LATCH)
				latch_cfg_r <= pwdata[15:0]; // RULE_12
			if (wr_en && paddr == `FPK_OFF_PASSWORD)
				password_r <= pwdata[15:0];
			// Mask widths bound the diagram to its object and value limits
			if (wr_en && paddr == `FPK_OFF_DIAG)
				diag_r <= pwdata[19:0]; // RULE_18 RULE_19
		end
	end

	// Cancel hold and key decoding
	logic [HW-1:0] hold_r;
	logic long_evt, short_evt;
	always_ff @(posedge clk_sys) begin
		if (rst)
			hold_r <= '0;
		else if (!pin_clean[`FPK_K_CANCEL])
			hold_r <= '0;
		else if (tick_r && hold_r != HW'(HOLD_TICKS))
			hold_r <= hold_r + HW'(1); // RULE_23
	end
	assign long_evt = tick_r & pin_clean[`FPK_K_CANCEL] & (hold_r == HW'(HOLD_TICKS - 1)); // RULE_01
	assign short_evt = pin_fall[`FPK_K_CANCEL] & (hold_r != HW'(HOLD_TICKS)); // RULE_01

	fpk_pkg::fpk_mode_e mode_r;
	logic info_arm_r;
	logic [1:0] digit_r;
	logic [15:0] entry_r;
	logic pwd_bad_r;
	logic [5:0] contrast_r;
	logic home_r;
	logic [7:0] alarms_r;
	logic key_clr;
	logic [8:0] nav_nxt;
	logic up_k, dn_k, lf_k, rt_k, inf_k, ent_k;
	assign up_k = pin_rise[`FPK_K_UP];
	assign dn_k = pin_rise[`FPK_K_DOWN];
	assign lf_k = pin_rise[`FPK_K_LEFT];
	assign rt_k = pin_rise[`FPK_K_RIGHT];
	assign inf_k = pin_rise[`FPK_K_INFO];
	assign ent_k = pin_rise[`FPK_K_ENTER];
	// Enter on the initial display acts as the latch reset key
	assign key_clr = (mode_r == fpk_pkg::FPK_MENU) & home_r & ent_k & ~info_arm_r; // RULE_13 RULE_14

	function automatic logic [3:0] bcd_step(input logic [3:0] d, input logic up);
		if (up)
			bcd_step = (d >= 4'h9) ? 4'h0 : d + 4'h1;
		else
			bcd_step = (d == 4'h0 || d > 4'h9) ? 4'h9 : d - 4'h1;
	endfunction : bcd_step

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_r <= fpk_pkg::FPK_MENU;
			info_arm_r <= 1'b0;
			digit_r <= 2'h0;
			entry_r <= 16'h0000;
			pwd_bad_r <= 1'b0;
			contrast_r <= `FPK_RST_CONTRAST;
		end else if (long_evt) begin
			mode_r <= fpk_pkg::FPK_MENU; // RULE_01
			info_arm_r <= 1'b0;
		end else begin
			case (mode_r)
				fpk_pkg::FPK_MENU: begin
					if (inf_k)
						info_arm_r <= 1'b1; // RULE_04
					else if (ent_k && info_arm_r) begin
						mode_r <= fpk_pkg::FPK_PWD; // RULE_16
						info_arm_r <= 1'b0;
						digit_r <= 2'h0;
						entry_r <= 16'h0000;
					end else if (up_k | dn_k | lf_k | rt_k | ent_k | short_evt)
						info_arm_r <= 1'b0;
				end
				fpk_pkg::FPK_PWD: begin
					if (up_k | dn_k)
						entry_r[digit_r*4 +: 4] <= bcd_step(entry_r[digit_r*4 +: 4], up_k); // RULE_02
					else if (lf_k)
						digit_r <= digit_r + 2'h1; // RULE_03
					else if (rt_k)
						digit_r <= digit_r - 2'h1; // RULE_03
					else if (ent_k) begin
						pwd_bad_r <= (entry_r != password_r); // RULE_05 RULE_16
						mode_r <= (entry_r == password_r) ? fpk_pkg::FPK_ADJ : fpk_pkg::FPK_MENU;
					end else if (short_evt)
						mode_r <= fpk_pkg::FPK_MENU;
				end
				fpk_pkg::FPK_ADJ: begin
					if (up_k && contrast_r != 6'h3F)
						contrast_r <= contrast_r + 6'h01; // RULE_16
					else if (dn_k && contrast_r != 6'h00)
						contrast_r <= contrast_r - 6'h01; // RULE_16
					else if (short_evt || ent_k)
						mode_r <= fpk_pkg::FPK_MENU;
				end
				default: mode_r <= fpk_pkg::FPK_MENU;
			endcase
			if (wr_en && paddr == `FPK_OFF_CONTRAST)
				contrast_r <= pwdata[5:0];
		end
	end

	// Alarm list: each short cancel in menu mode acknowledges one entry
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			alarms_r <= 8'h00;
			home_r <= 1'b0;
		end else begin
			if (alarm_new && !(short_evt && alarms_r != 8'h00 && mode_r == fpk_pkg::FPK_MENU)) begin
				if (alarms_r != 8'hFF)
					alarms_r <= alarms_r + 8'h01;
			end else if (!alarm_new && short_evt && alarms_r != 8'h00 && mode_r == fpk_pkg::FPK_MENU)
				alarms_r <= alarms_r - 8'h01; // RULE_14
			if (long_evt)
				home_r <= 1'b1; // RULE_13
			else if (short_evt && alarms_r == 8'h01 && !alarm_new && mode_r == fpk_pkg::FPK_MENU)
				home_r <= 1'b1; // RULE_14
			else if (up_k | dn_k | lf_k | rt_k | inf_k | (short_evt && alarms_r == 8'h00) | (mode_r != fpk_pkg::FPK_MENU))
				home_r <= 1'b0;
		end
	end

	// Navigation pulses to the menu firmware
	always_comb begin
		nav_nxt = 9'h000;
		if (mode_r == fpk_pkg::FPK_MENU) begin
			nav_nxt[0] = short_evt; // RULE_01
			nav_nxt[2] = up_k; // RULE_02
			nav_nxt[3] = dn_k; // RULE_02
			nav_nxt[4] = lf_k; // RULE_03
			nav_nxt[5] = rt_k; // RULE_03
			nav_nxt[6] = inf_k; // RULE_04
			nav_nxt[7] = ent_k & ~info_arm_r & ~home_r; // RULE_05
		end
		nav_nxt[1] = long_evt; // RULE_01
		nav_nxt[8] = key_clr;
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			nav_evt <= 9'h000;
			evt_sticky_r <= 9'h000;
		end else begin
			nav_evt <= nav_nxt;
			// New events win over a same-cycle write-one-to-clear
			evt_sticky_r <= (evt_sticky_r & ~((wr_en && paddr == `FPK_OFF_KEYEVT) ? pwdata[8:0] : 9'h000)) | nav_nxt;
		end
	end

	// Latching indicators and relays
	logic latch_clr;
	logic [CH-1:0] ch_src, ch_cfg, ch_out_r;
	assign latch_clr = key_clr | bus_clr_r | pin_rise[`FPK_K_CLRDI]; // RULE_13 RULE_15
	assign ch_src = {relay_src, app_src, opening_command_output, warning_output_group}; // RULE_09 RULE_10
	assign ch_cfg = {latch_cfg_r[8 +: RELAY_N], latch_cfg_r[4:0]};
	for (genvar c = 0; c < CH; c++) begin : g_ch
		always_ff @(posedge clk_sys) begin
			if (rst)
				ch_out_r[c] <= 1'b0;
			else
				ch_out_r[c] <= ch_src[c] | (ch_out_r[c] & ch_cfg[c] & ~latch_clr); // RULE_11 RULE_12
		end
	end
	assign led_alarm = ch_out_r[0];
	assign led_trip = ch_out_r[1];
	assign led_app = ch_out_r[4:2];
	assign relay_out = ch_out_r[CH-1:5];

	// Fixed indicators
	logic fault_d_r;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			led_power <= 1'b0;
			led_error <= 1'b0;
			self_sup_relay <= 1'b0;
			fault_d_r <= 1'b0;
			restart_req <= 1'b0;
			led_com <= 1'b0;
		end else begin
			led_power <= pin_clean[`FPK_K_PWR]; // RULE_06
			led_error <= int_fault; // RULE_07
			self_sup_relay <= int_fault; // RULE_07
			fault_d_r <= int_fault;
			restart_req <= int_fault & ~fault_d_r; // RULE_07
			// Traffic pulses invert the LED, blanking it while com_active is high, so a busy bus flashes it
			led_com <= com_active & ~com_traffic | com_traffic & ~com_active; // RULE_08
		end
	end

	// Backlight timer
	logic bl_sel, bl_prev_r, bl_edge;
	logic [BW-1:0] bl_cnt_r;
	always_comb begin
		case (fpk_pkg::fpk_blsrc_e'(blsrc_r))
			fpk_pkg::FPK_BL_DI: bl_sel = pin_clean[`FPK_K_BLDI]; // RULE_20
			fpk_pkg::FPK_BL_VIN: bl_sel = backlight_vin; // RULE_20
			fpk_pkg::FPK_BL_VOUT: bl_sel = backlight_vout; // RULE_20
			default: bl_sel = 1'b0;
		endcase
	end
	assign bl_edge = bl_sel & ~bl_prev_r;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bl_prev_r <= 1'b0;
			bl_cnt_r <= '0;
			backlight_on <= 1'b0;
		end else begin
			bl_prev_r <= bl_sel;
			if (bl_edge) begin
				bl_cnt_r <= BW'(BL_TICKS); // RULE_21 RULE_22
				backlight_on <= 1'b1;
			end else if (tick_r && bl_cnt_r != '0) begin
				bl_cnt_r <= bl_cnt_r - BW'(1);
				backlight_on <= (bl_cnt_r != BW'(1)); // RULE_21
			end
		end
	end
	assign contrast = contrast_r;

	// Register read data
	always_ff @(posedge clk_sys) begin
		if (rst)
			prdata <= 32'h00000000;
		else if (psel && !penable) begin
			case (paddr)
				`FPK_OFF_CTRL: prdata <= {29'h0, blsrc_r, 1'b0};
				`FPK_OFF_LATCH: prdata <= {16'h0, latch_cfg_r};
				`FPK_OFF_STATUS: prdata <= {10'h000, pwd_bad_r, mode_r, home_r, backlight_on,
					8'(ch_out_r[CH-1:5]), led_app, led_trip, led_alarm, led_com, led_error, led_power};
				`FPK_OFF_KEYEVT: prdata <= {23'h0, evt_sticky_r};
				`FPK_OFF_CONTRAST: prdata <= {26'h0, contrast_r};
				`FPK_OFF_PASSWORD: prdata <= {16'h0, password_r};
				`FPK_OFF_ALARMS: prdata <= {24'h0, alarms_r};
				`FPK_OFF_DIAG: prdata <= {12'h0, diag_r};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// Checks
	err_follows_relay_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_07
		(led_error == self_sup_relay) and (int_fault |=> led_error)) else $error("error LED differs from relay");
	power_led_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_06
		pin_clean[`FPK_K_PWR] |=> led_power) else $error("power LED not lit with supply");
	long_cancel_home_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_01
		long_evt |=> home_r && nav_evt[1] && mode_r == fpk_pkg::FPK_MENU) else $error("long cancel missed");
	latch_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_12
		led_alarm && ch_cfg[0] && !latch_clr |=> led_alarm) else $error("latched alarm LED dropped");
	unlatched_drop_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_11
		!ch_cfg[1] && !opening_command_output |=> !led_trip) else $error("unlatched trip LED stayed lit");
	clear_latch_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_15
		latch_clr && !warning_output_group |=> !led_alarm) else $error("latch clear ignored");
	bl_restart_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_22
		bl_edge |=> bl_cnt_r == BW'(BL_TICKS) && backlight_on) else $error("backlight period not restarted");
	bl_state_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_21
		backlight_on == (bl_cnt_r != '0)) else $error("backlight state and timer disagree");
	contrast_up_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_16
		mode_r == fpk_pkg::FPK_ADJ && up_k && !long_evt && contrast_r != 6'h3F && !wr_en
		|=> contrast_r == $past(contrast_r) + 6'h01) else $error("contrast not raised");
endmodule : fpk_front_panel

// ### test/fpk_operator.sv
// Operator model that presses the front panel push-buttons
`timescale 1ns/1ps
module fpk_operator (
	// Clock
	input wire logic clk_sys,
	// Buttons, active high
	output logic [6:0] key_raw
);
	initial key_raw = 7'h00;
	// The gap after release lets the debounced fall land before the next press
	task automatic tap(input int k, input int cyc);
		key_raw[k] <= 1'b1;
		repeat (cyc) @(posedge clk_sys);
		key_raw[k] <= 1'b0;
		repeat (30) @(posedge clk_sys);
	endtask : tap
	task automatic short_tap(input int k);
		// Kept well under the cancel hold time so it never counts as a long press
		tap(k, 12);
	endtask : short_tap
	task automatic long_hold();
		tap(0, 60);
	endtask : long_hold
endmodule : fpk_operator

// ### test/fpk_front_panel_bench.sv
// Self-checking bench for the front panel block
`timescale 1ns/1ps
module fpk_front_panel_bench;
	logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, relay_src, relay_out, rnd;
	logic [31:0] pwdata, prdata;
	logic [6:0] key_raw;
	logic aux_supply_pin, latch_clr_pin, backlight_di_pin, int_fault, com_active, com_traffic;
	logic warning_output_group, opening_command_output, backlight_vin, backlight_vout, alarm_new;
	logic [2:0] app_src, led_app;
	logic led_power, led_error, led_com, led_alarm, led_trip, self_sup_relay, restart_req, backlight_on;
	logic [5:0] contrast;
	logic [8:0] nav_evt;
	logic [8:0] evq[$];
	logic [64:0] rdq[$];
	logic [64:0] note;
	int fails, cmp_count;

	fpk_front_panel #(.TICK_CYC(4), .HOLD_TICKS(5), .BL_TICKS(20), .DEB_TICKS(1)) u_fpk_front_panel (
		.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.key_raw, .aux_supply_pin, .latch_clr_pin, .backlight_di_pin, .int_fault, .com_active, .com_traffic,
		.warning_output_group, .opening_command_output, .app_src, .relay_src, .backlight_vin, .backlight_vout,
		.alarm_new, .led_power, .led_error, .led_com, .led_alarm, .led_trip, .led_app, .relay_out,
		.self_sup_relay, .restart_req, .backlight_on, .contrast, .nav_evt
	);
	fpk_operator u_fpk_operator (.clk_sys, .key_raw);

	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic tmo();
		fails++;
		$display("[ERR] %0t wait ran out", $time);
		wrap_up();
	endtask : tmo

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	// For a read, d is the expected data under mask m
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic err);
		int n;
		if (!wr) rdq.push_back({err, m, d});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) tmo();
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle cycle keeps the release and the next setup apart
		@(posedge clk_sys);
	endtask : apb

	task automatic key(input int k, input logic [8:0] e);
		if (e !== 9'h000) evq.push_back(e);
		u_fpk_operator.short_tap(k);
	endtask : key

	task automatic wait_bl(input logic v, input int lim);
		int n;
		n = 0;
		while (backlight_on !== v && n < lim) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= lim) tmo();
		chk(backlight_on, v, "backlight");
	endtask : wait_bl

	task automatic trig(input int s, input logic v);
		case (s)
			0: backlight_di_pin <= v;
			1: backlight_vin <= v;
			default: backlight_vout <= v;
		endcase
		@(posedge clk_sys);
	endtask : trig

	task automatic pulse_src();
		rnd = lfsr(rnd);
		warning_output_group <= 1'b1;
		opening_command_output <= 1'b1;
		app_src <= rnd[2:0];
		relay_src <= rnd;
		repeat (2) @(posedge clk_sys);
		chk({led_alarm, led_trip}, 2'b11, "alarm and trip lit");
		warning_output_group <= 1'b0;
		opening_command_output <= 1'b0;
		app_src <= 3'h0;
		relay_src <= 8'h00;
		repeat (3) @(posedge clk_sys);
		chk({led_alarm, led_trip}, 2'b10, "only latched lamp held");
		chk({led_app, relay_out}, {rnd[2:0], rnd}, "latched outputs");
	endtask : pulse_src

	task automatic chk_clr();
		repeat (3) @(posedge clk_sys);
		chk({led_alarm, led_app, relay_out}, 12'h000, "latches cleared");
	endtask : chk_clr

	// Event and read-data notes are matched in arrival order
	always @(posedge clk_sys) begin
		if (nav_evt !== 9'h000) begin
			if (evq.size() == 0) chk(nav_evt, 9'h000, "stray key event");
			else chk(nav_evt, evq.pop_front(), "key event");
		end
		if (psel && penable && pready && !pwrite && rdq.size() > 0) begin
			note = rdq.pop_front();
			chk(prdata & note[63:32], note[31:0], "read data");
			chk(pslverr, note[64], "slave error");
		end
	end

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	initial begin : watchdog
		repeat (20000) @(posedge clk_sys);
		tmo();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, alarm_new} = '0;
		{aux_supply_pin, latch_clr_pin, backlight_di_pin, int_fault, com_active, com_traffic} = '0;
		{warning_output_group, opening_command_output, app_src, relay_src, backlight_vin, backlight_vout} = '0;
		fails = 0;
		cmp_count = 0;
		rnd = 8'h05;
		rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		apb(0, 8'h10, 32'h20, 32'hFFFFFFFF, 0);
		apb(1, 8'h08, 32'hFFFFFFFF, 0, 0);
		apb(0, 8'h08, 32'h0, 32'h0000FFFF, 0);
		apb(0, 8'h20, 32'h0, 32'hFFFFFFFF, 1);
		apb(1, 8'h1C, 32'hFFFFFFFF, 0, 0);
		apb(0, 8'h1C, 32'h000FFFFF, 32'hFFFFFFFF, 0);
		aux_supply_pin <= 1'b1;
		com_active <= 1'b1;
		int_fault <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk(restart_req, 1'b1, "restart request");
		repeat (28) @(posedge clk_sys);
		chk(restart_req, 1'b0, "restart request once");
		chk(led_power, 1'b1, "power lamp");
		chk({led_error, self_sup_relay}, 2'b11, "error lamp");
		chk(led_com, 1'b1, "com lamp");
		com_traffic <= 1'b1;
		int_fault <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(led_com, 1'b0, "com lamp flash");
		chk({led_error, self_sup_relay}, 2'b00, "error lamp off");
		com_traffic <= 1'b0;
		apb(1, 8'h04, 32'h0000FF1D, 0, 0);
		pulse_src();
		apb(1, 8'h00, 32'h1, 0, 0);
		chk_clr();
		pulse_src();
		latch_clr_pin <= 1'b1;
		repeat (30) @(posedge clk_sys);
		latch_clr_pin <= 1'b0;
		chk_clr();
		repeat (20) @(posedge clk_sys);
		key(6, 9'h080);
		for (int k = 1; k < 5; k++) key(k, 9'h001 << (k + 1));
		key(0, 9'h001);
		u_fpk_operator.tap(1, 1);
		apb(1, 8'h14, 32'h10, 0, 0);
		key(5, 9'h040);
		key(6, 9'h000);
		key(6, 9'h000);
		apb(0, 8'h08, 32'h00240000, 32'h003C0000, 0);
		key(5, 9'h040);
		key(6, 9'h000);
		key(3, 9'h000);
		key(1, 9'h000);
		key(6, 9'h000);
		apb(0, 8'h08, 32'h00100000, 32'h001C0000, 0);
		key(1, 9'h000);
		chk(contrast, 6'h21, "contrast up");
		key(2, 9'h000);
		key(2, 9'h000);
		chk(contrast, 6'h1F, "contrast down");
		key(6, 9'h000);
		apb(0, 8'h08, 32'h00040000, 32'h001C0000, 0);
		pulse_src();
		repeat (2) begin
			alarm_new <= 1'b1;
			@(posedge clk_sys);
			alarm_new <= 1'b0;
			@(posedge clk_sys);
		end
		apb(0, 8'h18, 32'h2, 32'hFFFFFFFF, 0);
		key(0, 9'h001);
		apb(0, 8'h18, 32'h1, 32'hFFFFFFFF, 0);
		key(0, 9'h001);
		apb(0, 8'h18, 32'h0, 32'hFFFFFFFF, 0);
		apb(0, 8'h08, 32'h00020000, 32'h00020000, 0);
		key(6, 9'h100);
		chk_clr();
		pulse_src();
		key(1, 9'h004);
		apb(0, 8'h08, 32'h00000000, 32'h00020000, 0);
		evq.push_back(9'h002);
		u_fpk_operator.long_hold();
		apb(0, 8'h08, 32'h00020000, 32'h00020000, 0);
		key(6, 9'h100);
		chk_clr();
		// The vin pass also retriggers to show the on-period restarting
		for (int s = 0; s < 3; s++) begin
			apb(1, 8'h00, s << 1, 0, 0);
			trig(s, 1'b1);
			wait_bl(1'b1, 40);
			trig(s, 1'b0);
			repeat (40) @(posedge clk_sys);
			if (s == 1) begin
				trig(1, 1'b1);
				trig(1, 1'b0);
			end
			repeat (25) @(posedge clk_sys);
			chk(backlight_on, 1'b1, "backlight held");
			if (s == 1) begin
				repeat (30) @(posedge clk_sys);
				chk(backlight_on, 1'b1, "backlight restarted");
			end
			wait_bl(1'b0, 100);
		end
		apb(1, 8'h00, 32'h6, 0, 0);
		apb(0, 8'h00, 32'h6, 32'hFFFFFFFF, 0);
		trig(1, 1'b1);
		trig(1, 1'b0);
		repeat (10) @(posedge clk_sys);
		chk(backlight_on, 1'b0, "backlight source off");
		aux_supply_pin <= 1'b0;
		repeat (30) @(posedge clk_sys);
		chk(led_power, 1'b0, "power lamp off");
		chk(evq.size(), 0, "events missing");
		wrap_up();
	end
endmodule : fpk_front_panel_bench
